// *** ref_clk_regs.svh ***
// register offsets, field positions, reset values and timing counts for reference clock logic
// Notes on behaviour
// - first output: direct clock, or divide by 256
// - second output: same, under its own bit
// - hiz bit 1 tristates output, 0 drives
// - three-bit field picks source line clock
// - first output held low on channel fault
// - second output held low on channel fault
// - fault forces low, never tristate
// - nrz alignment: first bit or last-bit centre
// - rail mode polarity 0: fourth frame bit
// - dejitter buffers add 29.5 line cycles
// - rx aux direction: 0 inputs, 1 outputs
// - rx aux source: separate clock or line
// - tx aux direction: 0 inputs, 1 outputs
// - tx aux source: separate clock or line
// - rx data after fall, sync every 256
// - tx sampled on rise, sync every 256
`ifndef REF_CLK_REGS_SVH
`define REF_CLK_REGS_SVH

`define REG_ADDR_W          13
`define REG_REF_ONE_ADDR    13'h0024
`define REG_REF_TWO_ADDR    13'h0025
`define REG_FRAME_ALIGN_ADDR 13'h000C
`define REG_AUX_CLK_ADDR    13'h0037

`define REF_DIV_BIT         7
`define REF_HIZ_BIT         6
`define REF_HOLD_BIT        5
`define REF_CHAN_MSB        2
`define FRAME_ALIGN_BIT     6
`define AUX_RX_DIR_BIT      0
`define AUX_RX_SRC_BIT      1
`define AUX_TX_DIR_BIT      2
`define AUX_TX_SRC_BIT      3

`define REF_CTRL_RESET      8'h00
`define REF_CTRL_MASK       8'hE7
`define FRAME_ALIGN_RESET   8'h00
`define FRAME_ALIGN_MASK    8'h40
`define AUX_CTRL_RESET      8'h00
`define AUX_CTRL_MASK       8'h0F

// divider counts both line clock edges: 256 cycles are 512 half steps
`define REF_HALF_W          9
`define REF_PULSE_HALF      9'h002
`define DEJITTER_HALF       9'h03B
`define ALIGN_NRZ_POS       9'h000
`define ALIGN_NRZ_NEG       9'h1FF
`define ALIGN_RAIL_POS      9'h006
`define ALIGN_RAIL_NEG      9'h007
`define AUX_FRAME_LAST      8'hFF

`endif

// *** ref_clk_pkg.sv ***
// types used by the reference clock frame alignment logic
package ref_clk_pkg;
  // gray ordered: one bit changes between neighbours
  typedef enum logic [1:0] {
    ALIGN_NRZ_POS  = 2'h0,
    ALIGN_NRZ_NEG  = 2'h1,
    ALIGN_RAIL_NEG = 2'h3,
    ALIGN_RAIL_POS = 2'h2
  } align_mode_t;
endpackage : ref_clk_pkg

// *** aux_word_fifo.sv ***
// word fifo with registered read stage
`timescale 1ns/1ns
module aux_word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             i_ref_clk,   // system clock
  input  wire logic             i_rst_b,     // async reset, active low
  input  wire logic [WIDTH-1:0] i_wr_data,   // word in
  input  wire logic             i_wr_valid,  // word in valid
  output logic                  o_wr_ready,  // room for a word
  output logic      [WIDTH-1:0] o_rd_data,   // word out, registered
  output logic                  o_rd_valid,  // word out valid
  input  wire logic             i_rd_ready   // drain side takes the word
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad
      $error("aux_word_fifo: depth must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic [WIDTH-1:0] out_r, out_nxt;
  logic             out_vld_r, out_vld_nxt;
  logic             push, pop;

  assign o_wr_ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ;
  assign o_rd_data  = out_r;
  assign o_rd_valid = out_vld_r;

  always_comb
  begin
    push        = i_wr_valid && o_wr_ready;
    pop         = (cnt_r != '0) && (!out_vld_r || i_rd_ready);
    wr_ptr_nxt  = push ? wr_ptr_r + AW'(1) : wr_ptr_r;
    rd_ptr_nxt  = pop ? rd_ptr_r + AW'(1) : rd_ptr_r;
    cnt_nxt     = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    out_nxt     = pop ? mem_r[rd_ptr_r] : out_r;
    out_vld_nxt = pop ? 1'b1 : (i_rd_ready ? 1'b0 : out_vld_r);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      cnt_r     <= '0;
      out_r     <= '0;
      out_vld_r <= 1'b0;
    end
    else
    begin
      wr_ptr_r  <= wr_ptr_nxt;
      rd_ptr_r  <= rd_ptr_nxt;
      cnt_r     <= cnt_nxt;
      out_r     <= out_nxt;
      out_vld_r <= out_vld_nxt;
    end
  end

  // storage carries no reset so it maps onto plain ram
  always_ff @(posedge i_ref_clk)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= i_wr_data;
    end
  end
endmodule : aux_word_fifo

// *** ref_clock_aux_port_timing.sv ***
// reference clock outputs, auxiliary port clocking and register port
`timescale 1ns/1ns
`include "ref_clk_regs.svh"
module ref_clock_aux_port_timing #(
  parameter int N_CHAN     = 8,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                   i_ref_clk,            // 100 MHz system clock
  input  wire logic                   i_rst_b,              // async reset, active low
  input  wire logic                   i_reg_cs,             // register access strobe
  input  wire logic                   i_reg_wr_en,          // 1 write, 0 read
  input  wire logic [`REG_ADDR_W-1:0] i_reg_addr,           // register address
  input  wire logic [7:0]             i_reg_wdata,          // write data
  output logic      [7:0]             o_reg_rdata,          // read data
  output logic                        o_reg_ack,            // access done, pulse
  input  wire logic [N_CHAN-1:0]      i_rx_line_clock,      // per channel line clock
  input  wire logic [N_CHAN-1:0]      i_los,                // per channel loss of signal
  input  wire logic [N_CHAN-1:0]      i_ext_loss_input,     // external loss, high active
  input  wire logic [N_CHAN-1:0]      i_ext_loss_enable,    // external loss honoured
  input  wire logic [N_CHAN-1:0]      i_rail_mode,          // 1 ami/hdb3, 0 nrz
  input  wire logic [N_CHAN-1:0]      i_rx_clock_polarity,  // per channel clock sense
  input  wire logic [N_CHAN-1:0]      i_dejitter_en,        // dejitter buffer on
  input  wire logic [N_CHAN-1:0]      i_frame_start,        // first frame bit marker
  input  wire logic                   i_separate_clock_in,  // separate clock source
  output logic                        o_ref_out_one,        // reference output one
  output logic                        o_ref_out_one_oe_b,   // its enable, low drives
  output logic                        o_ref_out_two,        // reference output two
  output logic                        o_ref_out_two_oe_b,   // its enable, low drives
  input  wire logic                   i_rx_aux_clock,       // rx aux clock pin in
  output logic                        o_rx_aux_clock,       // rx aux clock pin out
  output logic                        o_rx_aux_clock_oe_b,  // low drives
  input  wire logic                   i_rx_aux_sync,        // rx aux sync pin in
  output logic                        o_rx_aux_sync,        // rx aux sync pin out
  output logic                        o_rx_aux_sync_oe_b,   // low drives
  output logic                        o_rx_aux_data,        // rx aux serial data
  input  wire logic                   i_tx_aux_clock,       // tx aux clock pin in
  output logic                        o_tx_aux_clock,       // tx aux clock pin out
  output logic                        o_tx_aux_clock_oe_b,  // low drives
  input  wire logic                   i_tx_aux_sync,        // tx aux sync pin in
  output logic                        o_tx_aux_sync,        // tx aux sync pin out
  output logic                        o_tx_aux_sync_oe_b,   // low drives
  input  wire logic                   i_tx_aux_data,        // tx aux serial data
  input  wire logic [7:0]             i_rx_word,            // byte to send on rx aux
  input  wire logic                   i_rx_word_valid,      // byte valid
  output logic                        o_rx_word_ready,      // fifo has room
  output logic      [7:0]             o_tx_word,            // byte from tx aux
  output logic                        o_tx_word_valid       // byte valid, pulse
);
  generate
    if (N_CHAN < 2 || N_CHAN > 8)
    begin : g_bad
      $error("ref_clock_aux_port_timing: channel select is three bits wide");
    end
  endgenerate

  logic [7:0] ref_one_ctl_r, ref_one_ctl_nxt, ref_two_ctl_r, ref_two_ctl_nxt;
  logic [7:0] align_ctl_r, align_ctl_nxt, aux_ctl_r, aux_ctl_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic       ack_r, ack_nxt;
  logic       wr;

  always_comb
  begin
    wr              = i_reg_cs && i_reg_wr_en;
    ref_one_ctl_nxt = ref_one_ctl_r;
    ref_two_ctl_nxt = ref_two_ctl_r;
    align_ctl_nxt   = align_ctl_r;
    aux_ctl_nxt     = aux_ctl_r;
    rdata_nxt       = rdata_r;
    ack_nxt         = i_reg_cs;
    case (i_reg_addr)
      `REG_REF_ONE_ADDR:
      begin
        if (wr) ref_one_ctl_nxt = i_reg_wdata & `REF_CTRL_MASK;
        rdata_nxt = ref_one_ctl_r;
      end
      `REG_REF_TWO_ADDR:
      begin
        if (wr) ref_two_ctl_nxt = i_reg_wdata & `REF_CTRL_MASK;
        rdata_nxt = ref_two_ctl_r;
      end
      `REG_FRAME_ALIGN_ADDR:
      begin
        if (wr) align_ctl_nxt = i_reg_wdata & `FRAME_ALIGN_MASK;
        rdata_nxt = align_ctl_r;
      end
      `REG_AUX_CLK_ADDR:
      begin
        if (wr) aux_ctl_nxt = i_reg_wdata & `AUX_CTRL_MASK;
        rdata_nxt = aux_ctl_r;
      end
      default: rdata_nxt = 8'h00;
    endcase
    if (!i_reg_cs || wr) rdata_nxt = rdata_r;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ref_one_ctl_r <= `REF_CTRL_RESET;
      ref_two_ctl_r <= `REF_CTRL_RESET;
      align_ctl_r   <= `FRAME_ALIGN_RESET;
      aux_ctl_r     <= `AUX_CTRL_RESET;
      rdata_r       <= 8'h00;
      ack_r         <= 1'b0;
    end
    else
    begin
      ref_one_ctl_r <= ref_one_ctl_nxt;
      ref_two_ctl_r <= ref_two_ctl_nxt;
      align_ctl_r   <= align_ctl_nxt;
      aux_ctl_r     <= aux_ctl_nxt;
      rdata_r       <= rdata_nxt;
      ack_r         <= ack_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_reg_ack   = ack_r;

  // reference outputs: one generate slice per output
  logic [7:0] ref_ctl [2];
  logic [1:0] ref_out_w, ref_oe_b_w, ref_fault_w, ref_win_w;
  assign ref_ctl[0] = ref_one_ctl_r;
  assign ref_ctl[1] = ref_two_ctl_r;

  for (genvar g = 0; g < 2; g++)
  begin : g_ref
    logic [2:0]                ch;
    logic                      lvl, fault, rise, edge_any;
    ref_clk_pkg::align_mode_t  mode;
    logic [`REF_HALF_W-1:0]    target, hcnt_r, hcnt_nxt;
    logic                      lvl_q_r, out_r, out_nxt, oe_b_r, win;

    assign ch    = ref_ctl[g][`REF_CHAN_MSB:0];
    assign lvl   = i_rx_line_clock[ch];
    assign fault = i_los[ch] | (i_ext_loss_enable[ch] & i_ext_loss_input[ch]);

    always_comb
    begin
      rise     = lvl && !lvl_q_r;
      edge_any = lvl ^ lvl_q_r;
      mode     = ref_clk_pkg::align_mode_t'({i_rail_mode[ch], i_rx_clock_polarity[ch]});
      case (mode)
        ref_clk_pkg::ALIGN_NRZ_POS:  target = `ALIGN_NRZ_POS;
        ref_clk_pkg::ALIGN_NRZ_NEG:  target = `ALIGN_NRZ_NEG;
        ref_clk_pkg::ALIGN_RAIL_POS: target = `ALIGN_RAIL_POS;
        ref_clk_pkg::ALIGN_RAIL_NEG: target = `ALIGN_RAIL_NEG;
        default:                     target = `ALIGN_NRZ_POS;
      endcase
      if (!align_ctl_r[`FRAME_ALIGN_BIT]) target = `ALIGN_NRZ_POS;
      if (i_dejitter_en[ch]) target = target + `DEJITTER_HALF;
      hcnt_nxt = hcnt_r;
      if (rise && i_frame_start[ch]) hcnt_nxt = '0;
      else if (edge_any) hcnt_nxt = hcnt_r + `REF_HALF_W'(1);
      win      = (hcnt_nxt - target) < `REF_PULSE_HALF;
      // fault only pulls the level low; the enable stays with the hiz bit
      if (ref_ctl[g][`REF_HOLD_BIT] && fault) out_nxt = 1'b0;
      else if (ref_ctl[g][`REF_DIV_BIT]) out_nxt = win;
      else out_nxt = lvl;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
      if (!i_rst_b)
      begin
        lvl_q_r <= 1'b0;
        hcnt_r  <= '0;
        out_r   <= 1'b0;
        oe_b_r  <= 1'b0;
      end
      else
      begin
        lvl_q_r <= lvl;
        hcnt_r  <= hcnt_nxt;
        out_r   <= out_nxt;
        oe_b_r  <= ref_ctl[g][`REF_HIZ_BIT];
      end
    end

    assign ref_out_w[g]   = out_r;
    assign ref_oe_b_w[g]  = oe_b_r;
    assign ref_fault_w[g] = fault;
    assign ref_win_w[g]   = win;
  end

  assign o_ref_out_one      = ref_out_w[0];
  assign o_ref_out_one_oe_b = ref_oe_b_w[0];
  assign o_ref_out_two      = ref_out_w[1];
  assign o_ref_out_two_oe_b = ref_oe_b_w[1];

  // auxiliary port clocking; pin levels are sampled edges of i_ref_clk
  logic       rx_dir, rx_src, tx_dir, tx_src, line_one;
  logic       rx_gen_r, rx_q_r, rx_lvl, rx_rise, rx_fall, rx_sync_r, rx_sync_nxt;
  logic       tx_gen_r, tx_q_r, tx_lvl, tx_rise, tx_fall, tx_sync_r, tx_sync_nxt;
  logic [7:0] rx_cnt_r, rx_cnt_nxt, rx_sh_r, rx_sh_nxt, tx_cnt_r, tx_cnt_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt, tx_word_r, tx_word_nxt, fifo_data;
  logic       rx_dat_r, rx_dat_nxt, tx_vld_r, tx_vld_nxt, fifo_vld, fifo_pop;

  assign rx_dir   = aux_ctl_r[`AUX_RX_DIR_BIT];
  assign rx_src   = aux_ctl_r[`AUX_RX_SRC_BIT];
  assign tx_dir   = aux_ctl_r[`AUX_TX_DIR_BIT];
  assign tx_src   = aux_ctl_r[`AUX_TX_SRC_BIT];
  assign line_one = i_rx_line_clock[ref_one_ctl_r[`REF_CHAN_MSB:0]];

  aux_word_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .i_ref_clk  (i_ref_clk),
    .i_rst_b    (i_rst_b),
    .i_wr_data  (i_rx_word),
    .i_wr_valid (i_rx_word_valid),
    .o_wr_ready (o_rx_word_ready),
    .o_rd_data  (fifo_data),
    .o_rd_valid (fifo_vld),
    .i_rd_ready (fifo_pop)
  );

  always_comb
  begin
    rx_lvl      = rx_dir ? rx_gen_r : i_rx_aux_clock;
    rx_rise     = rx_lvl && !rx_q_r;
    rx_fall     = !rx_lvl && rx_q_r;
    rx_cnt_nxt  = rx_cnt_r;
    rx_sh_nxt   = rx_sh_r;
    rx_dat_nxt  = rx_dat_r;
    rx_sync_nxt = rx_sync_r;
    fifo_pop    = 1'b0;
    // slave sync taken on the rise; the first bit goes out on the next fall
    if (!rx_dir && rx_rise && i_rx_aux_sync) rx_cnt_nxt = `AUX_FRAME_LAST;
    if (rx_fall)
    begin
      rx_cnt_nxt  = rx_cnt_r + 8'h01;
      rx_sync_nxt = (rx_cnt_nxt == 8'h00);
      if (rx_cnt_nxt[2:0] == 3'h0)
      begin
        // an empty fifo sends an idle zero byte rather than stalling the line
        fifo_pop   = 1'b1;
        rx_sh_nxt  = fifo_vld ? {fifo_data[6:0], 1'b0} : 8'h00;
        rx_dat_nxt = fifo_vld & fifo_data[7];
      end
      else
      begin
        rx_sh_nxt  = {rx_sh_r[6:0], 1'b0};
        rx_dat_nxt = rx_sh_r[7];
      end
    end
  end

  always_comb
  begin
    tx_lvl      = tx_dir ? tx_gen_r : i_tx_aux_clock;
    tx_rise     = tx_lvl && !tx_q_r;
    tx_fall     = !tx_lvl && tx_q_r;
    tx_cnt_nxt  = tx_cnt_r;
    tx_sh_nxt   = tx_sh_r;
    tx_word_nxt = tx_word_r;
    tx_vld_nxt  = 1'b0;
    tx_sync_nxt = tx_sync_r;
    if (tx_fall) tx_sync_nxt = (tx_cnt_r == `AUX_FRAME_LAST);
    if (tx_rise)
    begin
      tx_cnt_nxt = (!tx_dir && i_tx_aux_sync) ? 8'h00 : tx_cnt_r + 8'h01;
      tx_sh_nxt  = {tx_sh_r[6:0], i_tx_aux_data};
      if (tx_cnt_nxt[2:0] == 3'h7)
      begin
        tx_word_nxt = tx_sh_nxt;
        tx_vld_nxt  = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_gen_r  <= 1'b0;
      rx_q_r    <= 1'b0;
      rx_cnt_r  <= 8'h00;
      rx_sh_r   <= 8'h00;
      rx_dat_r  <= 1'b0;
      rx_sync_r <= 1'b0;
      tx_gen_r  <= 1'b0;
      tx_q_r    <= 1'b0;
      tx_cnt_r  <= 8'h00;
      tx_sh_r   <= 8'h00;
      tx_word_r <= 8'h00;
      tx_vld_r  <= 1'b0;
      tx_sync_r <= 1'b0;
    end
    else
    begin
      rx_gen_r  <= rx_src ? i_separate_clock_in : line_one;
      rx_q_r    <= rx_lvl;
      rx_cnt_r  <= rx_cnt_nxt;
      rx_sh_r   <= rx_sh_nxt;
      rx_dat_r  <= rx_dat_nxt;
      rx_sync_r <= rx_sync_nxt;
      tx_gen_r  <= tx_src ? i_separate_clock_in : line_one;
      tx_q_r    <= tx_lvl;
      tx_cnt_r  <= tx_cnt_nxt;
      tx_sh_r   <= tx_sh_nxt;
      tx_word_r <= tx_word_nxt;
      tx_vld_r  <= tx_vld_nxt;
      tx_sync_r <= tx_sync_nxt;
    end
  end

  assign o_rx_aux_clock      = rx_gen_r;
  assign o_rx_aux_clock_oe_b = !rx_dir;
  assign o_rx_aux_sync       = rx_sync_r;
  assign o_rx_aux_sync_oe_b  = !rx_dir;
  assign o_rx_aux_data       = rx_dat_r;
  assign o_tx_aux_clock      = tx_gen_r;
  assign o_tx_aux_clock_oe_b = !tx_dir;
  assign o_tx_aux_sync       = tx_sync_r;
  assign o_tx_aux_sync_oe_b  = !tx_dir;
  assign o_tx_word           = tx_word_r;
  assign o_tx_word_valid     = tx_vld_r;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_one_fault;
    ref_one_ctl_r[`REF_HOLD_BIT] && ref_fault_w[0];
  endsequence
  sequence s_rx_master_fall;
    rx_dir && rx_fall;
  endsequence

  property p_ref_one_direct;
    !ref_one_ctl_r[`REF_DIV_BIT] && !(ref_one_ctl_r[`REF_HOLD_BIT] && ref_fault_w[0])
      |=> o_ref_out_one == $past(g_ref[0].lvl);
  endproperty
  a_ref_one_direct: assert property (p_ref_one_direct) else $error("ref one not direct");

  property p_ref_two_divided;
    ref_two_ctl_r[`REF_DIV_BIT] && !(ref_two_ctl_r[`REF_HOLD_BIT] && ref_fault_w[1])
      |=> o_ref_out_two == $past(ref_win_w[1]);
  endproperty
  a_ref_two_divided: assert property (p_ref_two_divided) else $error("ref two not divided");

  property p_hiz;
    ref_one_ctl_r[`REF_HIZ_BIT] ##1 ref_one_ctl_r[`REF_HIZ_BIT] |-> o_ref_out_one_oe_b;
  endproperty
  a_hiz: assert property (p_hiz) else $error("ref one driven while hiz set");

  property p_one_hold;
    s_one_fault |=> !o_ref_out_one;
  endproperty
  a_one_hold: assert property (p_one_hold) else $error("ref one not held low");

  property p_two_hold;
    ref_two_ctl_r[`REF_HOLD_BIT] && ref_fault_w[1] |=> !o_ref_out_two;
  endproperty
  a_two_hold: assert property (p_two_hold) else $error("ref two not held low");

  property p_fault_no_hiz;
    s_one_fault ##0 !ref_one_ctl_r[`REF_HIZ_BIT] |=> !o_ref_out_one_oe_b;
  endproperty
  a_fault_no_hiz: assert property (p_fault_no_hiz) else $error("fault tristated output");

  property p_frame_resync;
    g_ref[0].rise && i_frame_start[ref_one_ctl_r[2:0]] |=> g_ref[0].hcnt_r == 9'h000;
  endproperty
  a_frame_resync: assert property (p_frame_resync) else $error("divider not resynced");

  property p_rx_source;
    rx_src |=> o_rx_aux_clock == $past(i_separate_clock_in);
  endproperty
  a_rx_source: assert property (p_rx_source) else $error("rx aux source wrong");

  property p_tx_source;
    !tx_src |=> o_tx_aux_clock == $past(line_one);
  endproperty
  a_tx_source: assert property (p_tx_source) else $error("tx aux source wrong");

  property p_rx_data_on_fall;
    $changed(o_rx_aux_data) |-> $past(rx_fall);
  endproperty
  a_rx_data_on_fall: assert property (p_rx_data_on_fall) else $error("rx data off fall");

  property p_rx_sync_rate;
    s_rx_master_fall ##0 (rx_cnt_r == 8'hFF) |=> o_rx_aux_sync;
  endproperty
  a_rx_sync_rate: assert property (p_rx_sync_rate) else $error("rx sync missing");

  property p_tx_sync_on_fall;
    $rose(o_tx_aux_sync) |-> $past(tx_fall) && $past(tx_cnt_r) == 8'hFF;
  endproperty
  a_tx_sync_on_fall: assert property (p_tx_sync_on_fall) else $error("tx sync off fall");
endmodule : ref_clock_aux_port_timing

// *** line_side_model.sv ***
// far side model: line clocks, frame markers and slave aux port timing
`timescale 1ns/1ns
module line_side_model #(
  parameter logic [7:0] PATTERN = 8'hA5
) (
  input  wire logic       i_ref_clk,   // system clock
  output logic [7:0]      o_line_clk,  // per channel line clocks
  output logic [7:0]      o_frame,     // frame start markers
  output logic            o_aux_clk,   // slave aux clock, also separate clock
  output logic            o_aux_sync,  // slave aux sync
  output logic            o_aux_data   // tx aux serial data
);
  logic [11:0] cnt_r = 12'h000;
  logic [9:0]  ph;
  always_ff @(posedge i_ref_clk) cnt_r <= cnt_r + 12'h001;
  // each channel is offset by one count; line clocks repeat every four channels, so only frame markers tell channels four apart
  always_comb
    for (int k = 0; k < 8; k++)
    begin
      ph = cnt_r[9:0] + 10'(k);
      o_line_clk[k] = ph[1];
      o_frame[k] = (ph[9:2] == 8'h00);
    end
  // bits change after the aux fall so they are steady at the rise
  assign o_aux_clk  = cnt_r[3];
  assign o_aux_sync = (cnt_r[11:4] == 8'h00);
  assign o_aux_data = PATTERN[3'd7 - cnt_r[6:4]];
endmodule : line_side_model

// *** testbench.sv ***
// self-checking bench for reference clock outputs and aux port clocking
`timescale 1ns/1ns
module testbench;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cs = 1'b0, wr = 1'b0, run_rx = 1'b0, wvld = 1'b0, p1, p2;
  logic [12:0] addr = 13'h0000;
  logic [12:0] at [5] = '{13'h0024, 13'h0025, 13'h000C, 13'h0037, 13'h0026};
  logic [7:0]  wd = 8'h00, wrd = 8'h00, los = 8'h00, exl = 8'h00, exe = 8'h00;
  logic [7:0]  rd, tw, lc, fs;
  logic [7:0]  rm = 8'h00, cp = 8'h00, dj = 8'h00, bt = 8'h00;
  logic [7:0]  wq [$];
  logic        rxd, rxs;
  logic [7:0]  mdl [int];
  logic [1:0]  q, pq;
  logic        ack, r1, r1e, r2, r2e, ak, sy, dt, rac, tac, rce, rse, tce, tse, rdy, twv;
  int          n_fail = 0, total_checks = 0, cyc = 0, n, hi [2], rise [2];
  always #5 clk = ~clk;
  line_side_model i_line_side_model (.i_ref_clk(clk), .o_line_clk(lc), .o_frame(fs),
    .o_aux_clk(ak), .o_aux_sync(sy), .o_aux_data(dt));
  ref_clock_aux_port_timing i_ref_clock_aux_port_timing (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_reg_cs(cs), .i_reg_wr_en(wr), .i_reg_addr(addr),
    .i_reg_wdata(wd), .o_reg_rdata(rd), .o_reg_ack(ack), .i_rx_line_clock(lc), .i_los(los),
    .i_ext_loss_input(exl), .i_ext_loss_enable(exe), .i_rail_mode(rm),
    .i_rx_clock_polarity(cp), .i_dejitter_en(dj), .i_frame_start(fs),
    .i_separate_clock_in(ak), .o_ref_out_one(r1), .o_ref_out_one_oe_b(r1e),
    .o_ref_out_two(r2), .o_ref_out_two_oe_b(r2e), .i_rx_aux_clock(ak & run_rx),
    .o_rx_aux_clock(rac), .o_rx_aux_clock_oe_b(rce), .i_rx_aux_sync(sy), .o_rx_aux_sync(rxs),
    .o_rx_aux_sync_oe_b(rse), .o_rx_aux_data(rxd), .i_tx_aux_clock(ak), .o_tx_aux_clock(tac),
    .o_tx_aux_clock_oe_b(tce), .i_tx_aux_sync(sy), .o_tx_aux_sync(), .o_tx_aux_sync_oe_b(tse),
    .i_tx_aux_data(dt), .i_rx_word(wrd), .i_rx_word_valid(wvld), .o_rx_word_ready(rdy),
    .o_tx_word(tw), .o_tx_word_valid(twv));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [7:0] msk(input logic [12:0] a);
    return (a == at[0] || a == at[1]) ? 8'hE7 : (a == at[2]) ? 8'h40 :
           (a == at[3]) ? 8'h0F : 8'h00;
  endfunction : msk
  task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d);
    @(negedge clk);
    {cs, wr, addr, wd} = {1'b1, w, a, d};
    @(negedge clk);
    cs = 1'b0;
    chk("ack", 8'h01, {7'h00, ack});
    if (w)
      mdl[a] = d & msk(a);
    else
      chk("rdata", mdl.exists(a) ? mdl[a] : 8'h00, rd);
  endtask : acc
  task automatic refchk(input int c1, input int c2, input logic [1:0] low, input logic [1:0] hz);
    repeat (4) @(negedge clk);
    repeat (8)
    begin
      p1 = lc[c1] & ~low[0];
      p2 = lc[c2] & ~low[1];
      @(negedge clk);
      chk("ref_one", {7'h00, p1}, {7'h00, r1});
      if (!hz[1])
        chk("ref_two", {7'h00, p2}, {7'h00, r2});
      chk("ref_oe_b", {6'h00, hz}, {6'h00, r2e, r1e});
    end
  endtask : refchk
  task automatic tend(input string nm);
    $display("test %s done", nm);
  endtask : tend
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  initial
  begin
    void'($urandom(98));
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    for (int i = 0; i < 15; i++)
      acc(i >= 5 && i < 10, at[i % 5], 8'($urandom));
    tend("registers");
    for (int c = 0; c < 8; c++)
    begin
      acc(1'b1, at[0], 8'(c));
      acc(1'b1, at[1], 8'(7 - c));
      refchk(c, 7 - c, 2'b00, 2'b00);
    end
    tend("direct");
    n = int'($urandom_range(7));
    los[n] = 1'b1;
    acc(1'b1, at[0], 8'h20 | 8'(n));
    acc(1'b1, at[1], 8'h60 | 8'(n));
    refchk(n, n, 2'b11, 2'b10);
    {los[n], exe[n], exl[n]} = 3'b011;
    refchk(n, n, 2'b11, 2'b10);
    exe[n] = 1'b0;
    refchk(n, n, 2'b00, 2'b10);
    tend("fault");
    acc(1'b1, at[0], 8'h80);
    acc(1'b1, at[1], 8'h83);
    repeat (2048) @(negedge clk);
    hi = '{0, 0};
    rise = '{0, 0};
    pq = {r2, r1};
    repeat (2048)
    begin
      @(negedge clk);
      q = {r2, r1};
      for (int k = 0; k < 2; k++)
      begin
        hi[k] += int'(q[k]);
        rise[k] += int'(q[k] & ~pq[k]);
      end
      pq = q;
    end
    for (int k = 0; k < 2; k++)
    begin
      chk("div_high", 8'h08, 8'(hi[k]));
      chk("div_pulses", 8'h02, 8'(rise[k]));
    end
    tend("divide");
    acc(1'b1, at[2], 8'h40);
    acc(1'b1, at[1], 8'h81);
    for (int m = 0; m < 4; m++)
    begin
      {rm[1], cp[1], dj[1]} = {2'(m), 1'($urandom)};
      n = (m / 2 ? 6 + m % 2 : 511 * (m % 2)) + (dj[1] ? 59 : 0);
      n = (2 * (n % 512) + 1023) % 1024;
      repeat (m ? 40 : 1100) @(negedge clk);
      pq = {r2, r1};
      for (int i = 0; i < 1024; i++)
      begin
        @(negedge clk);
        q = {r2, r1};
        for (int k = 0; k < 2; k++)
          if (q[k] & ~pq[k])
            rise[k] = i;
        pq = q;
      end
      hi[0] = (rise[1] - rise[0] + 1024) % 1024;
      chk("align_offset", 16'(n), 16'(hi[0]));
    end
    tend("align");
    for (int m = 0; m < 2; m++)
    begin
      acc(1'b1, at[3], m ? 8'h0F : 8'h05);
      chk("aux_oe_b", 8'h00, {4'h0, rce, rse, tce, tse});
      repeat (8)
      begin
        p1 = m ? ak : lc[0];
        @(negedge clk);
        chk("rx_aux_clock", {7'h00, p1}, {7'h00, rac});
        chk("tx_aux_clock", {7'h00, p1}, {7'h00, tac});
      end
    end
    acc(1'b1, at[3], 8'h00);
    chk("aux_oe_b", 8'h0F, {4'h0, rce, rse, tce, tse});
    tend("aux pins");
    n = 0;
    repeat (24)
    begin
      @(negedge clk);
      wrd = 8'($urandom);
      wvld = 1'b1;
      if (rdy === 1'b1)
      begin
        n++;
        wq.push_back(wrd);
      end
    end
    @(negedge clk);
    wvld = 1'b0;
    chk("fifo_words", 8'h11, 8'(n));
    while (!(sy === 1'b1 && ak === 1'b0))
      @(negedge clk);
    run_rx = 1'b1;
    while (!(sy === 1'b0 && ak === 1'b1))
      @(negedge clk);
    for (int j = 0; j < 17; j++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        chk("rx_aux_sync", {7'h00, j == 0 && b == 0}, {7'h00, rxs});
        bt = {bt[6:0], rxd};
        repeat (16) @(negedge clk);
      end
      chk("rx_aux_data", wq.pop_front(), bt);
    end
    chk("rx_word_ready", 8'h01, {7'h00, rdy});
    tend("buffer");
    n = 0;
    while (twv !== 1'b1 && n < 600)
    begin
      @(negedge clk);
      n++;
    end
    chk("tx_word_valid", 8'h01, {7'h00, twv});
    chk("tx_word", 8'hA5, tw);
    tend("tx aux");
    end_of_test();
  end
endmodule : testbench
